// *** shared/monitor_status_config_regs.vh ***
`ifndef MONITOR_STATUS_CONFIG_REGS_VH
`define MONITOR_STATUS_CONFIG_REGS_VH

// Register offsets (byte addresses on the management bus)
`define OFS_STATUS            8'h02
`define OFS_STATUS_ALIAS      8'h34
`define OFS_CONFIG            8'h03
`define OFS_CONFIG_ALIAS      8'h09
`define OFS_CONV_RATE         8'h04
`define OFS_CONV_RATE_ALIAS   8'h0A
`define OFS_INT_HI_LIM        8'h05
`define OFS_INT_HI_LIM_ALIAS  8'h0B
`define OFS_INT_LO_LIM        8'h06
`define OFS_INT_LO_LIM_ALIAS  8'h0C
`define OFS_EXT_HI_LIM_H      8'h07
`define OFS_EXT_HI_LIM_H_ALIAS 8'h0D
`define OFS_EXT_LO_LIM_H      8'h08
`define OFS_EXT_LO_LIM_H_ALIAS 8'h0E
`define OFS_EXT_HI_LIM_L      8'h13
`define OFS_EXT_LO_LIM_L      8'h14

// Reset values
`define RST_STATUS            8'h00
`define RST_CONFIG            8'h00
`define RST_CONV_RATE         3'h6
`define RST_HI_LIM            8'h55
`define RST_LO_LIM            8'h80
`define RST_LIM_FRAC          3'h0

// Status field positions
`define ST_BUSY               7
`define ST_SPIKE              6
`define ST_OVER               4
`define ST_UNDER              3
`define ST_DIODE              2
`define ST_SEVERE             1

// Configuration field positions
`define CF_WARN_MASK          7
`define CF_TEMP_HALT          6
`define CF_WARN_COMP          5
`define CF_RESIST_OFF         4
`define CF_CURR_HALT          2
`define CF_AVG_OFF            1
`define CF_WRITE_MASK         8'hF6

// Timing: fastest rate is eight per second, slower rates double the period
`define EIGHTH_SEC_MS         125
`define CLK_MHZ               200
`define EIGHTH_SEC_CYCLES     (`EIGHTH_SEC_MS * 1000 * `CLK_MHZ)
`define RATE_SEL_MAX          3'h7

`endif

// *** src/monitor_status_config_regs.v ***
// Functional notes
// - Status bit 7 shows any conversion busy; never drives warning or critical output.
// - Status bit 6 follows the spike detector level; not sticky.
// - Spike drives critical output; warning only in comparator mode.
// - Status bit 4 sets on any high-limit hit; asserts warning.
// - Status bit 3 sets on any low-limit hit; asserts warning.
// - Status bit 2 sets on external diode fault; asserts warning.
// - Status bit 1 follows severe condition; drives critical output, clears when gone.
// - Over, under and severe flags clear when per-channel status is read/cleared.
// - Configuration and conversion rate answer identically at both addresses.
// - Warning mask suppresses warning in interrupt mode only; status still updates.
// - Configuration bit 5 picks interrupt (0) or comparator (1) warning mode.
// - Temperature halt stops temperature conversions; single trigger converts once.
// - Current halt stops shunt and supply conversions; single trigger converts once.
// - Configuration bit 4 disables series resistance correction for external diode.
// - Averaging off limits temperature channels to 1x averaging.
// - Rate select codes 0..7 give one per 16 s up to eight per second.
// - Rate paces temperature and supply conversions, not shunt conversions.
// - Temperature at or below low limit counts as a low-limit hit.
// - Temperature limit registers answer identically at both addresses, except the external fraction bytes, which have one address each.
// - New temperature limits act only from the next conversion onward.
// - Temperatures and limits use 11-bit two's complement, fraction left-justified.
// - Single trigger while temperature halted converts every temperature channel once.
`default_nettype none
`include "monitor_status_config_regs.vh"

module monitor_status_config_regs #(
    parameter EIGHTH_SEC_CYCLES = `EIGHTH_SEC_CYCLES
) (
    input  wire        ref_clk,
    input  wire        rst_n,
    // Register port from the management bus engine
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata_r,
    // Single-conversion trigger register write strobe
    input  wire        oneshot_wr,
    // Converter side
    input  wire        conv_busy,
    input  wire        temp_done,
    input  wire [10:0] int_temp,
    input  wire [10:0] ext_temp,
    input  wire        diode_fault,
    input  wire        spike_level,
    input  wire        volt_high_evt,
    input  wire        volt_low_evt,
    input  wire        severe_level,
    // Per-channel status read or clear strobes
    input  wire        high_status_clr,
    input  wire        low_status_clr,
    input  wire        crit_status_clr,
    input  wire        fault_status_clr,
    // Conversion control
    output reg         temp_conv_start_r,
    output reg         supply_conv_start_r,
    output reg         shunt_conv_start_r,
    output reg         shunt_run_r,
    output reg         series_resist_comp_off_r,
    output reg         avg_limit_1x_r,
    output reg  [2:0]  conversion_rate_sel_r,
    // Alarm outputs, active low
    output reg         warn_out_n_r,
    output reg         overheat_output_n_r
);

    //------------------------------------------------------------
    // Storage
    //------------------------------------------------------------
    reg  [7:0]  config_r;
    reg  [7:0]  int_hi_lim_r;
    reg  [7:0]  int_lo_lim_r;
    reg  [7:0]  ext_hi_lim_h_r;
    reg  [7:0]  ext_lo_lim_h_r;
    reg  [2:0]  ext_hi_lim_l_r;
    reg  [2:0]  ext_lo_lim_l_r;
    reg         over_r;
    reg         under_r;
    reg         diode_r;
    reg         severe_r;
    reg         severe_prev_r;
    reg  [31:0] tick_cnt_r;
    reg  [6:0]  eighth_cnt_r;
    reg  [7:0]  status_rd;
    reg  [7:0]  rdata_nxt;

    wire        temp_halt = config_r[`CF_TEMP_HALT];
    wire        curr_halt = config_r[`CF_CURR_HALT];
    wire        comp_mode = config_r[`CF_WARN_COMP];
    wire        warn_mask = config_r[`CF_WARN_MASK];

    //------------------------------------------------------------
    // Address decode, aliases map to one storage
    //------------------------------------------------------------
    wire wr_cfg    = reg_wr && (reg_addr == `OFS_CONFIG ||
                                reg_addr == `OFS_CONFIG_ALIAS);
    wire wr_rate   = reg_wr && (reg_addr == `OFS_CONV_RATE ||
                                reg_addr == `OFS_CONV_RATE_ALIAS);
    wire wr_int_hi = reg_wr && (reg_addr == `OFS_INT_HI_LIM ||
                                reg_addr == `OFS_INT_HI_LIM_ALIAS);
    wire wr_int_lo = reg_wr && (reg_addr == `OFS_INT_LO_LIM ||
                                reg_addr == `OFS_INT_LO_LIM_ALIAS);
    wire wr_ext_hh = reg_wr && (reg_addr == `OFS_EXT_HI_LIM_H ||
                                reg_addr == `OFS_EXT_HI_LIM_H_ALIAS);
    wire wr_ext_lh = reg_wr && (reg_addr == `OFS_EXT_LO_LIM_H ||
                                reg_addr == `OFS_EXT_LO_LIM_H_ALIAS);
    wire wr_ext_hl = reg_wr && (reg_addr == `OFS_EXT_HI_LIM_L);
    wire wr_ext_ll = reg_wr && (reg_addr == `OFS_EXT_LO_LIM_L);

    //------------------------------------------------------------
    // Writable registers
    //------------------------------------------------------------
    // Unused bits 3 and 0 of configuration stay zero
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            config_r              <= `RST_CONFIG;
            conversion_rate_sel_r <= `RST_CONV_RATE;
            int_hi_lim_r          <= `RST_HI_LIM;
            int_lo_lim_r          <= `RST_LO_LIM;
            ext_hi_lim_h_r        <= `RST_HI_LIM;
            ext_lo_lim_h_r        <= `RST_LO_LIM;
            ext_hi_lim_l_r        <= `RST_LIM_FRAC;
            ext_lo_lim_l_r        <= `RST_LIM_FRAC;
        end else begin
            if (wr_cfg) begin
                config_r <= reg_wdata & `CF_WRITE_MASK;
            end
            if (wr_rate) begin
                conversion_rate_sel_r <= reg_wdata[2:0];
            end
            if (wr_int_hi) begin
                int_hi_lim_r <= reg_wdata;
            end
            if (wr_int_lo) begin
                int_lo_lim_r <= reg_wdata;
            end
            if (wr_ext_hh) begin
                ext_hi_lim_h_r <= reg_wdata;
            end
            if (wr_ext_lh) begin
                ext_lo_lim_h_r <= reg_wdata;
            end
            // Fraction kept in the top three bits only
            if (wr_ext_hl) begin
                ext_hi_lim_l_r <= reg_wdata[7:5];
            end
            if (wr_ext_ll) begin
                ext_lo_lim_l_r <= reg_wdata[7:5];
            end
        end
    end

    //------------------------------------------------------------
    // Conversion pacing
    //------------------------------------------------------------
    // Period in eighth seconds is 2^(7 - sel); counting eighths keeps the
    // big divider one size for every rate.
    wire [6:0] period_m1 = (7'h01 << (`RATE_SEL_MAX - conversion_rate_sel_r)) - 7'h01;
    wire       tick      = (tick_cnt_r == EIGHTH_SEC_CYCLES - 1);
    wire       rate_hit  = tick && (eighth_cnt_r >= period_m1);

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            tick_cnt_r   <= 32'h0;
            eighth_cnt_r <= 7'h00;
        end else begin
            tick_cnt_r <= tick ? 32'h0 : tick_cnt_r + 32'h1;
            if (rate_hit) begin
                eighth_cnt_r <= 7'h00;
            end else if (tick) begin
                eighth_cnt_r <= eighth_cnt_r + 7'h01;
            end
        end
    end

    // Start strobes; a halted group converts only on the trigger write
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            temp_conv_start_r   <= 1'b0;
            supply_conv_start_r <= 1'b0;
            shunt_conv_start_r  <= 1'b0;
            shunt_run_r         <= 1'b0;
        end else begin
            temp_conv_start_r   <= temp_halt ? oneshot_wr : rate_hit;
            supply_conv_start_r <= curr_halt ? oneshot_wr : rate_hit;
            shunt_conv_start_r  <= curr_halt && oneshot_wr;
            shunt_run_r         <= !curr_halt;
        end
    end

    // Plain configuration outputs for the analog front end
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            series_resist_comp_off_r <= 1'b0;
            avg_limit_1x_r           <= 1'b0;
        end else begin
            series_resist_comp_off_r <= config_r[`CF_RESIST_OFF];
            avg_limit_1x_r           <= config_r[`CF_AVG_OFF];
        end
    end

    //------------------------------------------------------------
    // Limit comparison
    //------------------------------------------------------------
    // Signed 11-bit compares; internal limits are whole degrees.
    // Limits are sampled only at a finished conversion, so a limit
    // written while halted acts from the next conversion.
    wire signed [10:0] int_t   = int_temp;
    wire signed [10:0] ext_t   = ext_temp;
    wire signed [10:0] int_hi  = {int_hi_lim_r, 3'h0};
    wire signed [10:0] int_lo  = {int_lo_lim_r, 3'h0};
    wire signed [10:0] ext_hi  = {ext_hi_lim_h_r, ext_hi_lim_l_r};
    wire signed [10:0] ext_lo  = {ext_lo_lim_h_r, ext_lo_lim_l_r};

    wire temp_over  = temp_done && (int_t >= int_hi ||
                                    (!diode_fault && ext_t >= ext_hi));
    wire temp_under = temp_done && (int_t <= int_lo ||
                                    (!diode_fault && ext_t <= ext_lo));
    wire diode_set  = temp_done && diode_fault;

    //------------------------------------------------------------
    // Status flags
    //------------------------------------------------------------
    // A set arriving with its clear wins, so no event is lost
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            over_r        <= 1'b0;
            under_r       <= 1'b0;
            diode_r       <= 1'b0;
            severe_r      <= 1'b0;
            severe_prev_r <= 1'b0;
        end else begin
            severe_prev_r <= severe_level;
            if (temp_over || volt_high_evt) begin
                over_r <= 1'b1;
            end else if (high_status_clr) begin
                over_r <= 1'b0;
            end
            if (temp_under || volt_low_evt) begin
                under_r <= 1'b1;
            end else if (low_status_clr) begin
                under_r <= 1'b0;
            end
            if (diode_set) begin
                diode_r <= 1'b1;
            end else if (fault_status_clr) begin
                diode_r <= 1'b0;
            end
            // Severe sets on a new condition, drops when it goes away
            if (severe_level && !severe_prev_r) begin
                severe_r <= 1'b1;
            end else if (!severe_level || crit_status_clr) begin
                severe_r <= 1'b0;
            end
        end
    end

    // Status image; unused bits read zero
    always @* begin
        status_rd              = `RST_STATUS;
        status_rd[`ST_BUSY]    = conv_busy;
        status_rd[`ST_SPIKE]   = spike_level;
        status_rd[`ST_OVER]    = over_r;
        status_rd[`ST_UNDER]   = under_r;
        status_rd[`ST_DIODE]   = diode_r;
        status_rd[`ST_SEVERE]  = severe_r;
    end

    //------------------------------------------------------------
    // Alarm outputs
    //------------------------------------------------------------
    // Busy is left out of both alarms on purpose
    wire warn_src = over_r || under_r || diode_r;
    wire warn_act = comp_mode ? (warn_src || spike_level)
                              : (warn_src && !warn_mask);

    always @(posedge ref_clk) begin
        if (!rst_n) begin
            warn_out_n_r        <= 1'b1;
            overheat_output_n_r <= 1'b1;
        end else begin
            warn_out_n_r        <= !warn_act;
            overheat_output_n_r <= !(severe_r || spike_level);
        end
    end

    //------------------------------------------------------------
    // Read path
    //------------------------------------------------------------
    always @* begin
        case (reg_addr)
            `OFS_STATUS, `OFS_STATUS_ALIAS:          rdata_nxt = status_rd;
            `OFS_CONFIG, `OFS_CONFIG_ALIAS:          rdata_nxt = config_r;
            `OFS_CONV_RATE, `OFS_CONV_RATE_ALIAS:
                rdata_nxt = {5'h00, conversion_rate_sel_r};
            `OFS_INT_HI_LIM, `OFS_INT_HI_LIM_ALIAS:  rdata_nxt = int_hi_lim_r;
            `OFS_INT_LO_LIM, `OFS_INT_LO_LIM_ALIAS:  rdata_nxt = int_lo_lim_r;
            `OFS_EXT_HI_LIM_H, `OFS_EXT_HI_LIM_H_ALIAS: rdata_nxt = ext_hi_lim_h_r;
            `OFS_EXT_LO_LIM_H, `OFS_EXT_LO_LIM_H_ALIAS: rdata_nxt = ext_lo_lim_h_r;
            `OFS_EXT_HI_LIM_L: rdata_nxt = {ext_hi_lim_l_r, 5'h00};
            `OFS_EXT_LO_LIM_L: rdata_nxt = {ext_lo_lim_l_r, 5'h00};
            default:           rdata_nxt = 8'h00;
        endcase
    end

    // Read data holds until the next read strobe
    always @(posedge ref_clk) begin
        if (!rst_n) begin
            reg_rdata_r <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata_r <= rdata_nxt;
        end
    end

endmodule

`default_nettype wire

// *** verification/monitor_regs_sva.sv ***
`default_nettype none
`include "monitor_status_config_regs.vh"
// ----------------------------------------
// Port checker for the status and config bank
// ----------------------------------------
module monitor_regs_sva #(
    parameter EIGHTH_SEC_CYCLES = 8
) (
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata_r,
    input wire logic       oneshot_wr,
    input wire logic       conv_busy,
    input wire logic       spike_level,
    input wire logic       volt_high_evt,
    input wire logic       severe_level,
    input wire logic       high_status_clr,
    input wire logic       crit_status_clr,
    input wire logic       temp_conv_start_r,
    input wire logic       shunt_conv_start_r,
    input wire logic       shunt_run_r,
    input wire logic       series_resist_comp_off_r,
    input wire logic       avg_limit_1x_r,
    input wire logic [2:0] conversion_rate_sel_r,
    input wire logic       warn_out_n_r,
    input wire logic       overheat_output_n_r
);
    logic [7:0] cfg_r;
    // Config shadow: warning mode and halt bits decide what is legal
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            cfg_r <= 8'h00;
        else if (reg_wr && (reg_addr == `OFS_CONFIG || reg_addr == `OFS_CONFIG_ALIAS))
            cfg_r <= reg_wdata & `CF_WRITE_MASK;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Busy must be held steady, the read path may lag it by one cycle
    a_busy_readback: assert property ($stable(conv_busy) && reg_rd && (reg_addr == `OFS_STATUS
        || reg_addr == `OFS_STATUS_ALIAS) |=> reg_rdata_r[7] == $past(conv_busy))
        else $error("busy bit misread");
    a_spike_overheat: assert property (spike_level [*3] |-> !overheat_output_n_r)
        else $error("spike without critical output");
    a_severe_overheat: assert property ($rose(severe_level) ##1 !crit_status_clr
        |-> ##1 !overheat_output_n_r) else $error("severe without critical output");
    a_crit_release: assert property ((!severe_level && !spike_level) [*3]
        |-> overheat_output_n_r) else $error("critical output stuck");
    a_high_warns: assert property (volt_high_evt && (cfg_r[5] || !cfg_r[7]) ##1
        !high_status_clr |-> ##1 !warn_out_n_r) else $error("high hit without warning");
    a_mask_quiet: assert property ((cfg_r[7] && !cfg_r[5]) [*3] |-> warn_out_n_r)
        else $error("masked warning asserted");
    a_oneshot_temp: assert property (oneshot_wr && cfg_r[6] |=> temp_conv_start_r)
        else $error("trigger gave no temperature start");
    a_oneshot_shunt: assert property (oneshot_wr && cfg_r[2] |=> shunt_conv_start_r)
        else $error("trigger gave no shunt start");
    a_halt_quiet: assert property ((cfg_r[6] && !oneshot_wr) [*2] |-> !temp_conv_start_r)
        else $error("temperature start while halted");
    a_rate_alias: assert property (reg_wr && (reg_addr == `OFS_CONV_RATE
        || reg_addr == `OFS_CONV_RATE_ALIAS) |=> conversion_rate_sel_r == $past(reg_wdata[2:0]))
        else $error("rate write lost");
    a_cfg_levels: assert property ($stable(cfg_r) [*3] |-> series_resist_comp_off_r == cfg_r[4]
        && avg_limit_1x_r == cfg_r[1] && shunt_run_r == !cfg_r[2]) else $error("config level");
    c_oneshot: cover property (oneshot_wr && cfg_r[6] ##1 temp_conv_start_r);
    c_masked: cover property (volt_high_evt && cfg_r[7] && !cfg_r[5]);
    c_severe: cover property ($rose(severe_level) ##2 !overheat_output_n_r);
endmodule
bind monitor_status_config_regs monitor_regs_sva #(.EIGHTH_SEC_CYCLES(EIGHTH_SEC_CYCLES)) sva_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .oneshot_wr(oneshot_wr),
    .conv_busy(conv_busy), .spike_level(spike_level), .volt_high_evt(volt_high_evt),
    .severe_level(severe_level), .high_status_clr(high_status_clr),
    .crit_status_clr(crit_status_clr), .temp_conv_start_r(temp_conv_start_r),
    .shunt_conv_start_r(shunt_conv_start_r), .shunt_run_r(shunt_run_r),
    .series_resist_comp_off_r(series_resist_comp_off_r), .avg_limit_1x_r(avg_limit_1x_r),
    .conversion_rate_sel_r(conversion_rate_sel_r), .warn_out_n_r(warn_out_n_r),
    .overheat_output_n_r(overheat_output_n_r));
`default_nettype wire

// *** verification/host_model.sv ***
`default_nettype none
// ----------------------------------------
// Host side of the register strobe port
// ----------------------------------------
module host_model (
    input  wire logic       ref_clk,
    output var  logic [7:0] reg_addr,
    output var  logic [7:0] reg_wdata,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic       oneshot_wr,
    input  wire logic [7:0] reg_rdata_r
);
    // Idle: strobes low from time zero
    initial begin
        reg_addr = 8'hFF;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        oneshot_wr = 1'b0;
    end
    // Released lines get the inverse so stale values are never mistaken for live ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // Data is taken just after the edge that samples the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata_r;
    endtask
    // Single-conversion trigger; new limits act at the next finished conversion, not here
    task automatic trig();
        @(posedge ref_clk);
        oneshot_wr <= 1'b1;
        @(posedge ref_clk);
        oneshot_wr <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`default_nettype none
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int EIGHTH = 8;
    logic        ref_clk = 1'b0, rst_n = 1'b0, busy = 1'b0, done = 1'b0, flt = 1'b0;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata_r, rv, mem [0:255];
    logic        reg_wr, reg_rd, oneshot_wr, tst, sst, hst, hrun, rc_off, avg1, warn_n, hot_n;
    logic [2:0]  rate_sel;
    logic        spike = 1'b0, sevl = 1'b0, vhi = 1'b0, vlo = 1'b0, clr = 1'b0;
    logic [10:0] it = 11'h000, et = 11'h000;
    logic        over = 1'b0, under = 1'b0, diode = 1'b0, sev = 1'b0;
    int          failures = 0, n_compared = 0, nt = 0, ns = 0, nh = 0, bt, bs, bh;
    monitor_status_config_regs #(.EIGHTH_SEC_CYCLES(EIGHTH)) monitor_status_config_regs_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r), .oneshot_wr(oneshot_wr),
        .conv_busy(busy), .temp_done(done), .int_temp(it), .ext_temp(et), .diode_fault(flt),
        .spike_level(spike), .volt_high_evt(vhi), .volt_low_evt(vlo), .severe_level(sevl),
        .high_status_clr(clr), .low_status_clr(clr), .crit_status_clr(clr),
        .fault_status_clr(clr), .temp_conv_start_r(tst), .supply_conv_start_r(sst),
        .shunt_conv_start_r(hst), .shunt_run_r(hrun), .series_resist_comp_off_r(rc_off),
        .avg_limit_1x_r(avg1), .conversion_rate_sel_r(rate_sel), .warn_out_n_r(warn_n),
        .overheat_output_n_r(hot_n));
    host_model host_model_i (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .oneshot_wr(oneshot_wr), .reg_rdata_r(reg_rdata_r));
    initial forever #2.5 ref_clk = ~ref_clk;
    // Start pulse tallies for the pacing windows
    always @(posedge ref_clk) begin
        nt <= nt + int'(tst);
        ns <= ns + int'(sst);
        nh <= nh + int'(hst);
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Aliases sit six above the primary; masks drop the unused bits
    function automatic logic [7:0] twin(input logic [7:0] a);
        return (a >= 8'h03 && a <= 8'h08) ? a + 8'h06 : (a >= 8'h09 && a <= 8'h0E) ? a - 8'h06 : a;
    endfunction
    function automatic logic [7:0] wmask(input logic [7:0] a);
        logic [7:0] p;
        p = (a >= 8'h09 && a <= 8'h0E) ? a - 8'h06 : a;
        return p == 8'h03 ? 8'hF6 : p == 8'h04 ? 8'h07 : (p == 8'h13 || p == 8'h14) ? 8'hE0 :
            (p >= 8'h05 && p <= 8'h08) ? 8'hFF : 8'h00;
    endfunction
    task automatic mwr(input logic [7:0] a, input logic [7:0] d);
        host_model_i.wr(a, d);
        if (wmask(a) != 8'h00) begin
            mem[a] = d & wmask(a);
            mem[twin(a)] = mem[a];
        end
    endtask
    task automatic stat(input logic [7:0] a);
        logic w;
        // Model warning taken after the read so freshly driven levels have landed
        host_model_i.rd(a, rv);
        w = mem[3][5] ? (over | under | diode | spike) : (!mem[3][7] && (over | under | diode));
        chk(rv, {busy, spike, 1'b0, over, under, diode, sev, 1'b0});
        chk({7'h00, warn_n}, {7'h00, !w});
        chk({7'h00, hot_n}, {7'h00, !(sev | spike)});
    endtask
    // Compare rule: external is skipped on a diode fault
    task automatic tevt(input logic [10:0] ti, input logic [10:0] te, input logic f);
        @(posedge ref_clk);
        done <= 1'b1;
        it <= ti;
        et <= te;
        flt <= f;
        @(posedge ref_clk);
        done <= 1'b0;
        it <= ~ti;
        et <= ~te;
        over |= $signed(ti) >= $signed({mem[5], 3'h0}) ||
            (!f && $signed(te) >= $signed({mem[7], mem[8'h13][7:5]}));
        under |= $signed(ti) <= $signed({mem[6], 3'h0}) ||
            (!f && $signed(te) <= $signed({mem[8], mem[8'h14][7:5]}));
        diode |= f;
    endtask
    task automatic pulse(input int k);
        @(posedge ref_clk);
        {vhi, vlo, clr} <= 3'h4 >> k;
        @(posedge ref_clk);
        {vhi, vlo, clr} <= 3'h0;
        if (k == 0) over = 1'b1;
        if (k == 1) under = 1'b1;
        if (k == 2) {over, under, diode, sev} = 4'h0;
    endtask
    // Pacing window: starts per 64 cycles against the rate period
    task automatic window(input int et_, input int es, input int eh);
        {bt, bs, bh} = {nt, ns, nh};
        repeat (64) @(posedge ref_clk);
        #1 chk(8'(nt - bt), 8'(et_));
        chk(8'(ns - bs), 8'(es));
        chk(8'(nh - bh), 8'(eh));
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #400000 failures++;
        final_report();
    end
    initial begin
        void'($urandom(32'h45AE546B));
        foreach (mem[i]) mem[i] = 8'h00;
        {mem[4], mem[10]} = 16'h0606;
        {mem[5], mem[6], mem[7], mem[8]} = 32'h55805580;
        {mem[11], mem[12], mem[13], mem[14]} = 32'h55805580;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int r = 0; r < 4; r++) begin
            for (int a = 3; a <= 8'h14; a++) begin
                host_model_i.rd(8'(a), rv);
                chk(rv, mem[a]);
                chk({rc_off, avg1, hrun, 2'h0, rate_sel}, {mem[3][4], mem[3][1], !mem[3][2], 5'(mem[4])});
                mwr((r[0] ? twin(8'(a)) : 8'(a)), 8'($urandom));
            end
            mwr(8'h02, 8'hFF);
            stat(r[0] ? 8'h34 : 8'h02);
        end
        repeat (24) begin
            tevt(11'($urandom), 11'($urandom), ($urandom % 5) == 0);
            stat(8'h02);
            if (($urandom % 3) == 0) pulse(2);
        end
        pulse(2);
        tevt({mem[5], 3'h0}, {mem[8], mem[8'h14][7:5]}, 1'b0);
        stat(8'h34);
        tevt(11'h000, 11'h000, 1'b1);
        stat(8'h02);
        pulse(2);
        mwr(8'h03, 8'h80);
        pulse(0);
        stat(8'h02);
        mwr(8'h09, 8'hA0);
        pulse(1);
        stat(8'h02);
        pulse(2);
        mwr(8'h03, 8'h00);
        {spike, busy} <= 2'h3;
        stat(8'h34);
        mwr(8'h03, 8'h20);
        stat(8'h34);
        {spike, busy, sevl} <= 3'h1;
        sev = 1'b1;
        stat(8'h02);
        sevl <= 1'b0;
        sev = 1'b0;
        stat(8'h02);
        mwr(8'h0A, 8'hFF);
        repeat (64) @(posedge ref_clk);
        window(64 / EIGHTH, 64 / EIGHTH, 0);
        mwr(8'h04, 8'h05);
        repeat (64) @(posedge ref_clk);
        window(64 / (4 * EIGHTH), 64 / (4 * EIGHTH), 0);
        mwr(8'h03, 8'h44);
        repeat (64) @(posedge ref_clk);
        window(0, 0, 0);
        chk({7'h00, hrun}, 8'h00);
        fork
            host_model_i.trig();
            window(1, 1, 1);
        join
        final_report();
    end
endmodule
`default_nettype wire
